//--- apdu_card_end.sv
// Card-side transport end: header intake, procedure bytes, data return.
// Assumes an application that answers each header or block on rep_*.
`timescale 1ns/1ps
module apdu_card_end
  import apdu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link
  apdu_link_if.card lnk,
  // Header and command data to the application
  output logic hdr_vld,
  output logic [39:0] hdr_bytes,
  output logic app_dvld,
  output logic [7:0] app_dbyte,
  output logic app_dlast,
  // Response data from the application
  input wire logic rw_vld,
  input wire logic [7:0] rw_byte,
  // Application reply
  input wire logic rep_vld,
  input wire logic rep_want_data,
  input wire logic rep_resp,
  input wire logic [15:0] rep_sw
);
  typedef enum logic [2:0] {
    C_HDR = 3'b000,
    C_APP = 3'b001,
    C_SERVE = 3'b010,
    C_RX = 3'b011,
    C_PRE = 3'b100,
    C_DATA = 3'b101,
    C_SW1 = 3'b110,
    C_SW2 = 3'b111
  } card_state_t;

  card_state_t state_q;
  logic [7:0] mem [BUF_DEPTH];
  logic [7:0] hdr_q [HDR_LEN];
  logic [2:0] hcnt_q;
  logic [8:0] wr_ptr_q, rd_ptr_q, cnt_q, avail, le9;
  logic [15:0] tail_q, sw_q;
  logic rx_q, got_q, clr_buf;
  logic c_vld_q, c_end_q;
  logic [7:0] c_byte_q;

  assign avail = wr_ptr_q - rd_ptr_q;
  assign le9 = len_of(hdr_q[IDX_P3]);
  assign clr_buf = state_q == C_HDR && lnk.t_vld &&
    (lnk.t1_mode ? hcnt_q == 3'h0 :
     (hcnt_q == 3'(IDX_P3) && hdr_q[IDX_INS] != INS_GET_RESP));
  assign hdr_bytes = {hdr_q[IDX_CLA], hdr_q[IDX_INS], hdr_q[IDX_P1],
                      hdr_q[IDX_P2], hdr_q[IDX_P3]};
  assign lnk.c_vld = c_vld_q;
  assign lnk.c_end = c_end_q;
  assign lnk.c_byte = c_byte_q;

  // Response buffer; cleared when a fresh command starts
  always_ff @(posedge clk_sys) begin
    if (rw_vld && wr_ptr_q != LEN_FULL) begin
      mem[wr_ptr_q[7:0]] <= rw_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= LEN_ZERO;
    end else if (clr_buf) begin
      wr_ptr_q <= LEN_ZERO;
    end else if (rw_vld && wr_ptr_q != LEN_FULL) begin
      wr_ptr_q <= wr_ptr_q + LEN_ONE;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= C_HDR;
      for (int i = 0; i < HDR_LEN; i++) begin
        hdr_q[i] <= BYTE_ZERO;
      end
      hcnt_q <= 3'h0;
      rd_ptr_q <= LEN_ZERO;
      cnt_q <= LEN_ZERO;
      tail_q <= SW_OK;
      sw_q <= SW_OK;
      rx_q <= 1'b0;
      got_q <= 1'b0;
      c_vld_q <= 1'b0;
      c_end_q <= 1'b0;
      c_byte_q <= BYTE_ZERO;
      hdr_vld <= 1'b0;
      app_dvld <= 1'b0;
      app_dbyte <= BYTE_ZERO;
      app_dlast <= 1'b0;
    end else begin
      c_vld_q <= 1'b0;
      c_end_q <= 1'b0;
      hdr_vld <= 1'b0;
      app_dvld <= 1'b0;
      app_dlast <= 1'b0;
      case (state_q)
        C_HDR: if (lnk.t_vld) begin
          if (lnk.t1_mode) begin
            // Block field goes to the application unchanged
            app_dvld <= 1'b1;
            app_dbyte <= lnk.t_byte;
            app_dlast <= lnk.t_end;
            hcnt_q <= 3'h1;
            if (hcnt_q == 3'h0) rd_ptr_q <= LEN_ZERO;
            if (lnk.t_end) begin
              hcnt_q <= 3'h0;
              state_q <= C_APP;
            end
          end else begin
            hdr_q[hcnt_q] <= lnk.t_byte;
            hcnt_q <= hcnt_q + 3'h1;
            if (hcnt_q == 3'(IDX_P3)) begin
              hcnt_q <= 3'h0;
              if (hdr_q[IDX_INS] == INS_GET_RESP) begin
                state_q <= C_SERVE;
              end else begin
                hdr_vld <= 1'b1;
                got_q <= 1'b0;
                rd_ptr_q <= LEN_ZERO;
                sw_q <= SW_OK;
                state_q <= C_APP;
              end
            end
          end
        end
        C_SERVE: begin
          rx_q <= 1'b0;
          if (le9 > avail) begin
            // Asked for more than held: give the true length
            tail_q <= {PB_RELEN, avail[7:0]};
            cnt_q <= LEN_ZERO;
            state_q <= C_SW1;
          end else if (le9 == avail) begin
            tail_q <= sw_q;
            cnt_q <= avail;
            state_q <= C_PRE;
          end else begin
            tail_q <= {PB_MORE, 8'(avail - le9)};
            cnt_q <= le9;
            state_q <= C_PRE;
          end
        end
        C_APP: if (rep_vld) begin
          sw_q <= rep_sw;
          if (lnk.t1_mode) begin
            // Data only beside warning, application or normal status
            tail_q <= rep_sw;
            cnt_q <= sw_carries_data(rep_sw[15:8]) ? avail : LEN_ZERO;
            state_q <= (sw_carries_data(rep_sw[15:8]) && avail != LEN_ZERO)
                       ? C_DATA : C_SW1;
          end else if (rep_want_data) begin
            got_q <= 1'b1;
            rx_q <= 1'b1;
            cnt_q <= {1'b0, hdr_q[IDX_P3]};
            state_q <= C_PRE;
          end else if (rep_resp && got_q) begin
            // Never plain normal status after command data with a response due
            tail_q <= (rep_sw == SW_OK) ? {PB_MORE, avail[7:0]} : rep_sw;
            state_q <= C_SW1;
          end else if (rep_resp && rep_sw == SW_OK) begin
            state_q <= C_SERVE;
          end else begin
            tail_q <= rep_sw;
            state_q <= C_SW1;
          end
        end
        C_PRE: begin
          c_vld_q <= 1'b1;
          c_byte_q <= hdr_q[IDX_INS];
          state_q <= rx_q ? C_RX : (cnt_q != LEN_ZERO) ? C_DATA : C_SW1;
        end
        C_RX: if (lnk.t_vld) begin
          app_dvld <= 1'b1;
          app_dbyte <= lnk.t_byte;
          app_dlast <= cnt_q == LEN_ONE;
          cnt_q <= cnt_q - LEN_ONE;
          if (cnt_q == LEN_ONE) begin
            rx_q <= 1'b0;
            state_q <= C_APP;
          end
        end
        C_DATA: begin
          c_vld_q <= 1'b1;
          c_byte_q <= mem[rd_ptr_q[7:0]];
          rd_ptr_q <= rd_ptr_q + LEN_ONE;
          cnt_q <= cnt_q - LEN_ONE;
          if (cnt_q == LEN_ONE) state_q <= C_SW1;
        end
        C_SW1: begin
          c_vld_q <= 1'b1;
          c_byte_q <= tail_q[15:8];
          state_q <= C_SW2;
        end
        C_SW2: begin
          c_vld_q <= 1'b1;
          c_byte_q <= tail_q[7:0];
          c_end_q <= lnk.t1_mode;
          state_q <= C_HDR;
        end
        default: state_q <= C_HDR;
      endcase
    end
  end
endmodule : apdu_card_end

//--- apdu_pkg.sv
// Shared constants, codes and helpers for the message transport ends.
// Assumes both ends run on one clock and share this package.
package apdu_pkg;
  // Procedure bytes and status codes
  localparam logic [7:0] PB_NULL = 8'h60;
  localparam logic [7:0] PB_MORE = 8'h61;
  localparam logic [7:0] PB_RELEN = 8'h6C;
  localparam logic [7:0] SW1_WARN = 8'h62;
  localparam logic [7:0] SW1_WARN2 = 8'h63;
  localparam logic [3:0] SW1_APP_HI = 4'h9;
  localparam logic [15:0] SW_OK = 16'h9000;
  localparam logic [7:0] INS_GET_RESP = 8'hC0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  // Header layout and sizes
  localparam int HDR_LEN = 5;
  localparam int IDX_CLA = 0;
  localparam int IDX_INS = 1;
  localparam int IDX_P1 = 2;
  localparam int IDX_P2 = 3;
  localparam int IDX_P3 = 4;
  localparam int APDU_MAX = 261;
  localparam int BUF_DEPTH = 256;
  localparam logic [8:0] LEN_FULL = 9'h100;
  localparam logic [8:0] LEN_CASE1 = 9'h004;
  localparam logic [8:0] LEN_CASE2 = 9'h005;
  localparam logic [8:0] LEN_ONE = 9'h001;
  localparam logic [8:0] LEN_ZERO = 9'h000;

  typedef enum logic [1:0] {
    CASE1 = 2'b00,
    CASE2 = 2'b01,
    CASE3 = 2'b10,
    CASE4 = 2'b11
  } apdu_case_t;

  // Warning, application or normal status: may carry data
  function automatic logic sw_carries_data(input logic [7:0] sw1);
    return sw1 == SW1_WARN || sw1 == SW1_WARN2 || sw1[7:4] == SW1_APP_HI;
  endfunction : sw_carries_data

  function automatic logic sw_continue(input logic [15:0] sw);
    return sw_carries_data(sw[15:8]) && sw != SW_OK;
  endfunction : sw_continue

  // Length byte zero stands for the full 256
  function automatic logic [8:0] len_of(input logic [7:0] p3);
    return (p3 == BYTE_ZERO) ? LEN_FULL : {1'b0, p3};
  endfunction : len_of
endpackage : apdu_pkg

//--- apdu_link_if.sv
// Byte link between terminal transport end and card transport end.
// Assumes one byte per cycle each way; receivers always take it.
`timescale 1ns/1ps
interface apdu_link_if;
  logic t1_mode;
  logic t_vld;
  logic t_end;
  logic [7:0] t_byte;
  logic c_vld;
  logic c_end;
  logic [7:0] c_byte;

  modport term (
    output t1_mode,
    output t_vld,
    output t_end,
    output t_byte,
    input c_vld,
    input c_end,
    input c_byte
  );
  modport card (
    input t1_mode,
    input t_vld,
    input t_end,
    input t_byte,
    output c_vld,
    output c_end,
    output c_byte
  );
endinterface : apdu_link_if

//--- apdu_term_end.sv
// Terminal-side transport end: takes a command message, maps it onto the
// link in either protocol and returns the response message.
// Assumes a card end that answers one byte per cycle at most.
//
// How it works
// - Case 4 header carries Lc, Le dropped
// - Send data after procedure byte, stop on status
// - Card answers 61xx or status after data
// - Get response length within signalled length
// - Warning or 9xxx other than 9000 after case 4 data: get response
// - Other status after data ends the command
// - Get response handled as case 2
// - 6Cxx resends previous header with new length
// - 61/6C only for case 2 and 4
// - Too long request answered 6C or error
// - Matching request returns data then status
// - Short request returns data then 61xx
// - Card never gives 9000 after case 4 data
// - Retrieved data passes unchanged to response
// - Block protocol carries messages unchanged
// - Block data only with warning/9xxx status
// - Command data sent unaltered in blocks
// - Block response taken from the first field, bytes in order
// - Four cases by data presence each way
// - Only status words end a command
`timescale 1ns/1ps
module apdu_term_end
  import apdu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Link
  apdu_link_if.term lnk,
  // Command message in
  input wire logic proto_t1,
  input wire logic cmd_vld,
  input wire logic [7:0] cmd_byte,
  input wire logic cmd_last,
  output logic cmd_rdy,
  // Response message out
  output logic rsp_vld,
  output logic [7:0] rsp_byte,
  output logic rsp_last,
  output logic busy
);
  typedef enum logic [3:0] {
    T_IDLE = 4'b0000,
    T_CLASS = 4'b0001,
    T_HDR = 4'b0010,
    T_WPB = 4'b0011,
    T_DATA = 4'b0100,
    T_RDAT = 4'b0101,
    T_WSW2 = 4'b0110,
    T_SW2 = 4'b0111,
    T_T1TX = 4'b1000,
    T_T1RX = 4'b1001
  } term_state_t;

  term_state_t state_q;
  logic [7:0] msg [APDU_MAX];
  logic [7:0] hdr_q [HDR_LEN];
  logic [8:0] len_q, idx_q, cnt_q;
  logic [7:0] sw1_q, sw2_q, t_byte_q;
  logic t1_q, dat_q, d4_q, t_vld_q, t_end_q;
  apdu_case_t case_q, cls;
  logic get_resp;

  // Case from the message length and the P3 byte alone
  function automatic apdu_case_t classify(input logic [8:0] n,
                                          input logic [7:0] b4);
    if (n == LEN_CASE1) return CASE1;
    if (n == LEN_CASE2) return CASE2;
    if (n == LEN_CASE2 + {1'b0, b4}) return CASE3;
    return CASE4;
  endfunction : classify

  assign cls = classify(len_q, msg[IDX_P3]);
  assign cmd_rdy = state_q == T_IDLE && len_q != 9'(APDU_MAX);
  assign busy = state_q != T_IDLE;
  assign lnk.t1_mode = t1_q;
  assign lnk.t_vld = t_vld_q;
  assign lnk.t_end = t_end_q;
  assign lnk.t_byte = t_byte_q;
  // More bytes pending, or warning or 9xxx status other than 9000 after case 4 data
  assign get_resp = sw1_q == PB_MORE ||
                    (d4_q && sw_continue({sw1_q, lnk.c_byte}));

  // Message store; no reset needed for the array itself
  always_ff @(posedge clk_sys) begin
    if (cmd_vld && cmd_rdy) begin
      msg[len_q] <= cmd_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= T_IDLE;
      for (int i = 0; i < HDR_LEN; i++) begin
        hdr_q[i] <= BYTE_ZERO;
      end
      len_q <= LEN_ZERO;
      idx_q <= LEN_ZERO;
      cnt_q <= LEN_ZERO;
      sw1_q <= BYTE_ZERO;
      sw2_q <= BYTE_ZERO;
      case_q <= CASE1;
      t1_q <= 1'b0;
      dat_q <= 1'b0;
      d4_q <= 1'b0;
      t_vld_q <= 1'b0;
      t_end_q <= 1'b0;
      t_byte_q <= BYTE_ZERO;
      rsp_vld <= 1'b0;
      rsp_byte <= BYTE_ZERO;
      rsp_last <= 1'b0;
    end else begin
      t_vld_q <= 1'b0;
      t_end_q <= 1'b0;
      rsp_vld <= 1'b0;
      rsp_last <= 1'b0;
      case (state_q)
        T_IDLE: if (cmd_vld && cmd_rdy) begin
          len_q <= len_q + LEN_ONE;
          if (cmd_last) begin
            t1_q <= proto_t1;
            state_q <= T_CLASS;
          end
        end
        T_CLASS: begin
          case_q <= cls;
          hdr_q[IDX_CLA] <= msg[IDX_CLA];
          hdr_q[IDX_INS] <= msg[IDX_INS];
          hdr_q[IDX_P1] <= msg[IDX_P1];
          hdr_q[IDX_P2] <= msg[IDX_P2];
          // Case 1 gets a zero length; case 4 sends Lc, drops Le
          hdr_q[IDX_P3] <= (cls == CASE1) ? BYTE_ZERO
                                          : msg[IDX_P3];
          dat_q <= cls == CASE3 || cls == CASE4;
          d4_q <= 1'b0;
          idx_q <= LEN_ZERO;
          state_q <= t1_q ? T_T1TX : T_HDR;
        end
        T_HDR: begin
          t_vld_q <= 1'b1;
          t_byte_q <= hdr_q[idx_q[2:0]];
          idx_q <= idx_q + LEN_ONE;
          if (idx_q == 9'(IDX_P3)) state_q <= T_WPB;
        end
        T_WPB: if (lnk.c_vld) begin
          if (lnk.c_byte == PB_NULL) begin
            state_q <= T_WPB;
          end else if (lnk.c_byte == hdr_q[IDX_INS] && dat_q) begin
            idx_q <= 9'(HDR_LEN);
            state_q <= T_DATA;
          end else if (lnk.c_byte == hdr_q[IDX_INS]) begin
            cnt_q <= len_of(hdr_q[IDX_P3]);
            state_q <= T_RDAT;
          end else begin
            // Status or 61/6C pair; nothing reaches the user yet
            sw1_q <= lnk.c_byte;
            state_q <= T_WSW2;
          end
        end
        T_DATA: begin
          t_vld_q <= 1'b1;
          t_byte_q <= msg[idx_q];
          idx_q <= idx_q + LEN_ONE;
          if (idx_q == 9'(IDX_P3) + {1'b0, msg[IDX_P3]}) begin
            dat_q <= 1'b0;
            d4_q <= case_q == CASE4;
            state_q <= T_WPB;
          end
        end
        T_RDAT: if (lnk.c_vld) begin
          // Returned data passes straight through
          rsp_vld <= 1'b1;
          rsp_byte <= lnk.c_byte;
          cnt_q <= cnt_q - LEN_ONE;
          if (cnt_q == LEN_ONE) state_q <= T_WPB;
        end
        T_WSW2: if (lnk.c_vld) begin
          d4_q <= 1'b0;
          if (get_resp) begin
            // Length taken as signalled, or zero after a warning or 9xxx status
            hdr_q[IDX_INS] <= INS_GET_RESP;
            hdr_q[IDX_P1] <= BYTE_ZERO;
            hdr_q[IDX_P2] <= BYTE_ZERO;
            hdr_q[IDX_P3] <= (sw1_q == PB_MORE) ? lnk.c_byte
                                                : BYTE_ZERO;
            dat_q <= 1'b0;
            idx_q <= LEN_ZERO;
            state_q <= T_HDR;
          end else if (sw1_q == PB_RELEN) begin
            hdr_q[IDX_P3] <= lnk.c_byte;
            idx_q <= LEN_ZERO;
            state_q <= T_HDR;
          end else begin
            // Any other status finishes the command
            rsp_vld <= 1'b1;
            rsp_byte <= sw1_q;
            sw2_q <= lnk.c_byte;
            state_q <= T_SW2;
          end
        end
        T_SW2: begin
          rsp_vld <= 1'b1;
          rsp_byte <= sw2_q;
          rsp_last <= 1'b1;
          len_q <= LEN_ZERO;
          state_q <= T_IDLE;
        end
        T_T1TX: begin
          // Whole message in one block field, unchanged
          t_vld_q <= 1'b1;
          t_byte_q <= msg[idx_q];
          idx_q <= idx_q + LEN_ONE;
          if (idx_q == len_q - LEN_ONE) begin
            t_end_q <= 1'b1;
            state_q <= T_T1RX;
          end
        end
        T_T1RX: if (lnk.c_vld) begin
          // Field bytes pass straight through; the first field end closes the message
          rsp_vld <= 1'b1;
          rsp_byte <= lnk.c_byte;
          rsp_last <= lnk.c_end;
          if (lnk.c_end) begin
            len_q <= LEN_ZERO;
            state_q <= T_IDLE;
          end
        end
        default: state_q <= T_IDLE;
      endcase
    end
  end
endmodule : apdu_term_end

//--- apdu_transport_mapper_checker.sv
// Link checker: watches the byte link between the two transport ends.
// Assumes the bench instantiates it beside the link; one clock domain.
`timescale 1ns/1ps
module apdu_transport_mapper_checker
  import apdu_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Terminal to card
  input wire logic t1_mode,
  input wire logic t_vld,
  input wire logic t_end,
  input wire logic [7:0] t_byte,
  // Card to terminal
  input wire logic c_vld,
  input wire logic c_end,
  input wire logic [7:0] c_byte
);
  logic [8:0] tcnt_q;
  logic [8:0] ccnt_q;
  logic [7:0] c1_q;
  logic [7:0] kind_q;
  logic [7:0] len_q;
  logic [7:0] ins_q;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  // Byte index within the current burst of each direction
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tcnt_q <= '0;
      ccnt_q <= '0;
    end else if (c_vld) begin
      tcnt_q <= '0;
      ccnt_q <= ccnt_q + 9'h001;
    end else if (t_vld) begin
      tcnt_q <= tcnt_q + 9'h001;
      ccnt_q <= '0;
    end
  end

  // First card pair of a burst; outside block mode data bytes never open a burst
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      c1_q <= '0;
      kind_q <= '0;
      len_q <= '0;
    end else if (c_vld && ccnt_q == 9'h000) begin
      c1_q <= c_byte;
    end else if (c_vld && ccnt_q == 9'h001) begin
      kind_q <= c1_q;
      len_q <= c_byte;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ins_q <= '0;
    end else if (t_vld && tcnt_q == 9'h001) begin
      ins_q <= t_byte;
    end
  end

  chk_half_duplex: assert property (!(t_vld && c_vld))
    else $error("both ends drive the link in one cycle");
  chk_t_end_mode: assert property (t_end |-> t_vld && t1_mode)
    else $error("terminal field end outside block mode");
  chk_c_end_mode: assert property (c_end |-> c_vld && t1_mode)
    else $error("card field end outside block mode");
  chk_t_end_stop: assert property (t_end |=> !t_vld)
    else $error("terminal byte after field end");
  chk_gr_ins: assert property (
    kind_q == PB_MORE && !t1_mode && t_vld && tcnt_q == 9'h001
    |-> t_byte == INS_GET_RESP)
    else $error("retrieval header without get response code");
  chk_gr_len: assert property (
    kind_q == PB_MORE && !t1_mode && t_vld && tcnt_q == 9'h004
    |-> len_q == 8'h00 || (t_byte != 8'h00 && t_byte <= len_q))
    else $error("retrieval length above signalled length");
  chk_relen_p3: assert property (
    kind_q == PB_RELEN && !t1_mode && t_vld && tcnt_q == 9'h004
    |-> t_byte == len_q)
    else $error("resent header length differs from card length");
  chk_relen_ins: assert property (
    kind_q == PB_RELEN && !t1_mode && t_vld && tcnt_q == 9'h001
    |-> t_byte == ins_q)
    else $error("resent header has another instruction");
  chk_relen_soon: assert property (c_vld && ccnt_q == 9'h001
    && c1_q == PB_RELEN && !t1_mode |-> ##[1:16] t_vld)
    else $error("header not resent promptly");
  chk_pair_whole: assert property (
    c_vld && ccnt_q == 9'h000 && !t1_mode
    && (c_byte == PB_MORE || c_byte == PB_RELEN) |-> ##[1:4] c_vld)
    else $error("procedure byte without its length byte");

  cover property (c_vld && ccnt_q == 9'h001 && c1_q == PB_MORE && !t1_mode);
  cover property (c_vld && ccnt_q == 9'h001 && c1_q == PB_RELEN && !t1_mode);
  cover property (t_end);
  cover property (c_end);
endmodule : apdu_transport_mapper_checker

//--- apdu_transport_mapper_bench.sv
// Self-checking bench: terminal end and card end joined over the link.
// Assumes the bench plays both applications; one 200 MHz clock.
`timescale 1ns/1ps
`define CHECK(what, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("[ERR] %s expected %h seen %h", what, exp, got); \
    end \
  end
module apdu_transport_mapper_bench;
  typedef struct packed {
    logic t1;
    logic [3:0] mlen;
    logic [71:0] msg;
    logic [3:0] lc;
    logic [7:0] nd;
    logic resp;
    logic [15:0] sw;
  } row_t;
  localparam int NROW = 13;
  // Messages right-aligned, first byte highest
  localparam logic [71:0] C1 = 72'h00A4_0000;
  localparam logic [71:0] C2 = 72'h00_B000_0000;
  localparam logic [71:0] C2_LE1 = 72'h00_B000_0001;
  localparam logic [71:0] C2_LE2 = 72'h00_B000_0002;
  localparam logic [71:0] C2_LE4 = 72'h00_B000_0004;
  localparam logic [71:0] C3 = 72'h00_D600_0002_1122;
  localparam logic [71:0] C4 = 72'h0088_0000_0211_2200;
  logic clk_sys, reset_n, proto_t1, cmd_vld, cmd_last, cmd_rdy;
  logic rsp_vld, rsp_last, busy, hdr_vld, app_dvld, app_dlast;
  logic rw_vld, rep_vld, rep_want_data, rep_resp;
  logic [7:0] cmd_byte, rsp_byte, app_dbyte, rw_byte;
  logic [39:0] hdr_bytes;
  logic [15:0] rep_sw;
  int err_total;
  int checks;
  int app_idx;
  row_t cur;
  row_t rows [NROW];
  logic [7:0] got_q [$];
  logic [7:0] exp_q [$];

  apdu_link_if i_apdu_link_if ();
  apdu_term_end i_apdu_term_end (.clk_sys(clk_sys), .reset_n(reset_n),
    .lnk(i_apdu_link_if.term), .proto_t1(proto_t1), .cmd_vld(cmd_vld),
    .cmd_byte(cmd_byte), .cmd_last(cmd_last), .cmd_rdy(cmd_rdy),
    .rsp_vld(rsp_vld), .rsp_byte(rsp_byte), .rsp_last(rsp_last), .busy(busy));
  apdu_card_end i_apdu_card_end (.clk_sys(clk_sys), .reset_n(reset_n),
    .lnk(i_apdu_link_if.card), .hdr_vld(hdr_vld), .hdr_bytes(hdr_bytes),
    .app_dvld(app_dvld), .app_dbyte(app_dbyte), .app_dlast(app_dlast),
    .rw_vld(rw_vld), .rw_byte(rw_byte), .rep_vld(rep_vld),
    .rep_want_data(rep_want_data), .rep_resp(rep_resp), .rep_sw(rep_sw));
  apdu_transport_mapper_checker i_apdu_transport_mapper_checker (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .t1_mode(i_apdu_link_if.t1_mode), .t_vld(i_apdu_link_if.t_vld),
    .t_end(i_apdu_link_if.t_end), .t_byte(i_apdu_link_if.t_byte),
    .c_vld(i_apdu_link_if.c_vld), .c_end(i_apdu_link_if.c_end),
    .c_byte(i_apdu_link_if.c_byte));

  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task complete_run;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic send_cmd(input row_t r);
    cur = r;
    app_idx = 0;
    proto_t1 = r.t1;
    for (int i = 0; i < r.mlen; i++) begin
      cmd_vld = 1'b1;
      cmd_byte = r.msg[8 * (r.mlen - 1 - i) +: 8];
      cmd_last = (i == r.mlen - 1);
      while (cmd_rdy !== 1'b1) @(negedge clk_sys);
      @(negedge clk_sys);
    end
    cmd_vld = 1'b0;
    cmd_last = 1'b0;
  endtask : send_cmd

  task automatic run_row(input row_t r);
    int n;
    send_cmd(r);
    `CHECK("busy", 1'b1, busy)
    exp_q = {};
    got_q = {};
    // Data rides only on ok, warning or application status
    if (r.resp && (r.sw[15:12] == 4'h9 || r.sw[15:9] == 7'h31)) begin
      for (int k = 0; k < r.nd; k++) exp_q.push_back(8'h30 + 8'(k));
    end
    exp_q.push_back(r.sw[15:8]);
    exp_q.push_back(r.sw[7:0]);
    n = 0;
    while (n < 3000 && !(rsp_vld === 1'b1 && rsp_last === 1'b1)) begin
      @(negedge clk_sys);
      if (rsp_vld === 1'b1) got_q.push_back(rsp_byte);
      n++;
    end
    `CHECK("rsp count", exp_q.size(), got_q.size())
    foreach (exp_q[k]) begin
      if (k < got_q.size())
        `CHECK("rsp byte", exp_q[k], got_q[k])
    end
    @(negedge clk_sys);
  endtask : run_row

  // Card application: fills the buffer unless it asks for command data, then replies once
  task automatic app_reply(input logic want);
    if (!want) begin
      for (int k = 0; k < cur.nd; k++) begin
        rw_vld = 1'b1;
        rw_byte = 8'h30 + 8'(k);
        @(negedge clk_sys);
      end
    end
    rw_vld = 1'b0;
    rep_vld = 1'b1;
    rep_want_data = want;
    rep_resp = cur.resp;
    rep_sw = cur.sw;
    @(negedge clk_sys);
    rep_vld = 1'b0;
    rep_want_data = 1'b0;
  endtask : app_reply

  initial begin
    int pos;
    int last_pos;
    logic [7:0] exp_b;
    logic [31:0] exp_h;
    forever begin
      @(negedge clk_sys);
      if (app_dvld === 1'b1) begin
        pos = cur.t1 ? app_idx : app_idx + 5;
        // Last flag on final field byte, or final command data byte
        last_pos = cur.t1 ? cur.mlen - 1 : cur.lc + 4;
        exp_b = cur.msg[8 * (cur.mlen - 1 - pos) +: 8];
        `CHECK("app byte", exp_b, app_dbyte)
        `CHECK("app last", pos == last_pos, app_dlast)
        app_idx++;
      end
      if (hdr_vld === 1'b1 && !cur.t1) begin
        exp_h = cur.msg[8 * (cur.mlen - 4) +: 32];
        `CHECK("hdr", exp_h, hdr_bytes[39:8])
        if (cur.lc != 4'h0 || cur.mlen == 4'h4)
          `CHECK("hdr p3", {4'h0, cur.lc}, hdr_bytes[7:0])
        app_reply(cur.lc != 4'h0);
      end else if (app_dlast === 1'b1) begin
        app_reply(1'b0);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    $display("[ERR] watchdog expected done seen hang");
    complete_run;
  end

  initial begin
    err_total = 0;
    checks = 0;
    reset_n = 1'b0;
    proto_t1 = 1'b0;
    cmd_vld = 1'b0;
    cmd_byte = 8'h00;
    cmd_last = 1'b0;
    rw_vld = 1'b0;
    rw_byte = 8'h00;
    rep_vld = 1'b0;
    rep_want_data = 1'b0;
    rep_resp = 1'b0;
    rep_sw = 16'h0000;
    cur = '0;
    rows[0] = {1'b0, 4'h4, C1, 4'h0, 8'h00, 1'b0, 16'h9000};
    rows[1] = {1'b0, 4'h5, C2_LE2, 4'h0, 8'h02, 1'b1, 16'h9000};
    rows[2] = {1'b0, 4'h5, C2_LE4, 4'h0, 8'h02, 1'b1, 16'h9000};
    rows[3] = {1'b0, 4'h5, C2, 4'h0, 8'h03, 1'b1, 16'h9000};
    rows[4] = {1'b0, 4'h7, C3, 4'h2, 8'h00, 1'b0, 16'h9000};
    rows[5] = {1'b0, 4'h8, C4, 4'h2, 8'h03, 1'b1, 16'h9000};
    rows[6] = {1'b0, 4'h8, C4, 4'h2, 8'h02, 1'b1, 16'h6281};
    rows[7] = {1'b0, 4'h8, C4, 4'h2, 8'h01, 1'b1, 16'h9110};
    rows[8] = {1'b0, 4'h8, C4, 4'h2, 8'h00, 1'b0, 16'h6A82};
    rows[9] = {1'b1, 4'h8, C4, 4'h2, 8'h02, 1'b1, 16'h9000};
    rows[10] = {1'b1, 4'h8, C4, 4'h2, 8'h02, 1'b1, 16'h6A82};
    rows[11] = {1'b1, 4'h5, C2_LE2, 4'h0, 8'h02, 1'b1, 16'h6300};
    // Short request: part now, rest fetched after 61xx
    rows[12] = {1'b0, 4'h5, C2_LE1, 4'h0, 8'h02, 1'b1, 16'h9000};
    repeat (20) @(negedge clk_sys);
    reset_n = 1'b1;
    @(negedge clk_sys);
    `CHECK("idle ready", 1'b1, cmd_rdy)
    `CHECK("idle rsp", 1'b0, rsp_vld)
    for (int r = 0; r < NROW; r++) run_row(rows[r]);
    // Reset in mid-command, then a clean command must still complete
    send_cmd(rows[5]);
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (6) @(negedge clk_sys);
    `CHECK("busy after reset", 1'b0, busy)
    run_row(rows[1]);
    complete_run;
  end
endmodule : apdu_transport_mapper_bench
